// ### design/tq_pkg.sv
// Constants and types for the translation query outcome checker
package tq_pkg;
  localparam int CODE_W = 8;
  localparam int TAG_W = 16;
  // Result codes
  localparam logic [7:0] RES_SUCCESS = 8'h00;
  localparam logic [7:0] RES_MALFORMED = 8'hFF;
  localparam logic [7:0] RES_ABSENT_STAGE = 8'hFE;
  localparam logic [7:0] RES_STREAM_RANGE = 8'h02;
  localparam logic [7:0] RES_STREAM_FETCH = 8'h03;
  localparam logic [7:0] RES_STREAM_INVALID = 8'h04;
  localparam logic [7:0] RES_STREAM_BLOCKED = 8'h06;
  localparam logic [7:0] RES_SUBSTREAM_RANGE = 8'h08;
  localparam logic [7:0] RES_DESC_FETCH = 8'h09;
  localparam logic [7:0] RES_DESC_INVALID = 8'h0A;
  localparam logic [7:0] RES_VMS_FETCH = 8'h25;
  // Query type codes
  localparam logic [1:0] QT_STAGE1 = 2'h1;
  localparam logic [1:0] QT_STAGE2 = 2'h2;
  localparam logic [1:0] QT_BOTH = 2'h3;
  // Stream regime codes
  localparam logic [1:0] REGIME_NS_EL1 = 2'h0;
  localparam logic [1:0] REGIME_SECURE = 2'h1;
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [TAG_W-1:0] ZERO_TAG = 16'h0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } state_t;
endpackage : tq_pkg

// ### design/tq_stage_check.sv
// Stage compatibility and guest tag selection for one fetched stream entry
`timescale 1ns/10ps
module tq_stage_check (
  // Query
  input wire logic [1:0] query_type,
  input wire logic guest_scoped,
  // Entry
  input wire logic s1_en,
  input wire logic s2_en,
  input wire logic entry_secure,
  input wire logic [1:0] stream_regime,
  input wire logic [15:0] stage2_guest_tag,
  // Results
  output logic stage_ok,
  output logic tag_present,
  output logic [15:0] eff_tag
);
  import tq_pkg::*;
  wire need_s1 = (query_type == QT_STAGE1) || (query_type == QT_BOTH);
  wire need_s2 = (query_type == QT_STAGE2) || (query_type == QT_BOTH);
  // Guest queries need stage 1; stage 2 only entries are refused
  wire guest_ok = s1_en;
  assign stage_ok = guest_scoped ? guest_ok : ((!need_s1 || s1_en) && (!need_s2 || s2_en));
  wire ns_el1 = !entry_secure && (stream_regime == REGIME_NS_EL1);
  wire sec_s1only = entry_secure && (stream_regime == REGIME_SECURE) && s1_en && !s2_en;
  assign tag_present = s2_en || ns_el1 || sec_s1only;
  // Secure stage-1-only entries tag with zero
  assign eff_tag = sec_s1only ? ZERO_TAG : stage2_guest_tag;
endmodule : tq_stage_check

// ### design/translation_query_fault_check.sv
// Outcome prioritisation for translation queries and guest-scoped queries
`timescale 1ns/10ps
// Function
// - Report errors in fixed thirteen-step priority
// - Malformed decided from query alone, first
// - Late absent-stage check after valid entry
// - Absent-stage overrides all later errors
// - Secure non-guest stage2 query without secure stage2: early
// - Secure stage2 supported: decide late
// - VM fetch abort ranks below entry invalid
// - Guest query: check type, malformed if bad
// - Guest query fetches selected stream entry
// - Untagged entry gives entry invalid
// - Tag mismatch gives entry invalid
// - Matching but unsuitable stages: absent stage
// - Passing guest checks allows later outcomes
// - NS EL1 entry uses stage2 tag
// - Secure stage1-only entry uses zero tag
// - Encode outcomes with fixed result codes; walk faults pass their own
module translation_query_fault_check (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Query request
  input wire logic query_start,
  input wire logic guest_scoped,
  input wire logic [1:0] query_type,
  input wire logic query_type_valid,
  input wire logic secure_query_flag,
  input wire logic secure_stage2_supported,
  input wire logic [tq_pkg::TAG_W-1:0] guest_query_selector,
  // Stream entry fetch results
  input wire logic fetch_done,
  input wire logic stream_index_range_error,
  input wire logic stream_entry_fetch_abort,
  input wire logic stream_entry_valid,
  input wire logic vm_structure_fetch_abort,
  input wire logic entry_s1_en,
  input wire logic entry_s2_en,
  input wire logic entry_secure,
  input wire logic [1:0] stream_regime,
  input wire logic [tq_pkg::TAG_W-1:0] stage2_guest_tag,
  // Later stage results
  input wire logic substream_range_error,
  input wire logic substream_blocked,
  input wire logic desc_stage2_fault,
  input wire logic [tq_pkg::CODE_W-1:0] desc_stage2_code,
  input wire logic descriptor_fetch_abort,
  input wire logic descriptor_invalid_error,
  input wire logic translation_fault,
  input wire logic [tq_pkg::CODE_W-1:0] translation_code,
  // Outcome
  output logic busy,
  output logic fetch_req,
  output logic result_valid,
  output logic [tq_pkg::CODE_W-1:0] result_code
);
  import tq_pkg::*;

  state_t state_r, state_nxt;
  logic busy_r, fetch_req_r, result_valid_r;
  logic [CODE_W-1:0] result_code_r, result_code_nxt;
  logic stage_ok, tag_present;
  logic [TAG_W-1:0] eff_tag;

  tq_stage_check u_stage (
    .query_type(query_type),
    .guest_scoped(guest_scoped),
    .s1_en(entry_s1_en),
    .s2_en(entry_s2_en),
    .entry_secure(entry_secure),
    .stream_regime(stream_regime),
    .stage2_guest_tag(stage2_guest_tag),
    .stage_ok(stage_ok),
    .tag_present(tag_present),
    .eff_tag(eff_tag)
  );

  // State decode
  wire in_idle = (state_r == ST_IDLE);
  wire in_wait = (state_r == ST_WAIT);
  wire take_query = in_idle && query_start;
  wire take_fetch = in_wait && fetch_done;

  // Point A: decided from the query alone, before any fetch
  wire malformed = !query_type_valid;
  wire wants_s2 = (query_type == QT_STAGE2) || (query_type == QT_BOTH);
  wire secure_no_s2 = secure_query_flag && !secure_stage2_supported;
  // Guest queries leave absent stage to the entry checks
  wire early_absent = secure_no_s2 && wants_s2 && !guest_scoped;

  // Point B: decided from the fetched entry and later walk results
  wire guest_untagged = guest_scoped && !tag_present;
  wire guest_mismatch = guest_scoped && tag_present && (eff_tag != guest_query_selector);
  wire entry_invalid = !stream_entry_valid || guest_untagged || guest_mismatch;
  wire late_absent = !stage_ok;

  // Named causes, most urgent first
  wire hit_malformed = in_idle && malformed;
  wire hit_early_absent = in_idle && early_absent;
  // Point B causes count only while the fetch answer is awaited
  wire hit_range = in_wait && stream_index_range_error;
  wire hit_entry_fetch = in_wait && stream_entry_fetch_abort;
  wire hit_entry_invalid = in_wait && entry_invalid;
  wire hit_vm_fetch = in_wait && vm_structure_fetch_abort;
  wire hit_late_absent = in_wait && late_absent;
  wire hit_substream = in_wait && substream_range_error;
  wire hit_blocked = in_wait && substream_blocked;
  wire hit_desc_stage2 = in_wait && desc_stage2_fault;
  wire hit_desc_fetch = in_wait && descriptor_fetch_abort;
  wire hit_desc_invalid = in_wait && descriptor_invalid_error;
  wire hit_translation = in_wait && translation_fault;

  // Outcome table, entry 0 is the most urgent
  wire [12:0] rank_hit;
  wire [CODE_W-1:0] rank_code [13];
  assign rank_hit[0] = hit_malformed;
  assign rank_code[0] = RES_MALFORMED;
  assign rank_hit[1] = hit_early_absent;
  assign rank_code[1] = RES_ABSENT_STAGE;
  assign rank_hit[2] = hit_range;
  assign rank_code[2] = RES_STREAM_RANGE;
  assign rank_hit[3] = hit_entry_fetch;
  assign rank_code[3] = RES_STREAM_FETCH;
  assign rank_hit[4] = hit_entry_invalid;
  assign rank_code[4] = RES_STREAM_INVALID;
  // Free to sit lower; kept just under entry invalid
  assign rank_hit[5] = hit_vm_fetch;
  assign rank_code[5] = RES_VMS_FETCH;
  // Absent stage outranks every substream, descriptor and walk cause
  assign rank_hit[6] = hit_late_absent;
  assign rank_code[6] = RES_ABSENT_STAGE;
  assign rank_hit[7] = hit_substream;
  assign rank_code[7] = RES_SUBSTREAM_RANGE;
  assign rank_hit[8] = hit_blocked;
  assign rank_code[8] = RES_STREAM_BLOCKED;
  // Stage-2 descriptor and translation faults bring their own fault codes; descriptor fetch and invalid use fixed codes
  assign rank_hit[9] = hit_desc_stage2;
  assign rank_code[9] = desc_stage2_code;
  assign rank_hit[10] = hit_desc_fetch;
  assign rank_code[10] = RES_DESC_FETCH;
  assign rank_hit[11] = hit_desc_invalid;
  assign rank_code[11] = RES_DESC_INVALID;
  assign rank_hit[12] = hit_translation;
  assign rank_code[12] = translation_code;

  // A rank wins only while every more urgent rank is clear
  wire [12:0] rank_above;
  wire [12:0] rank_win;
  wire [CODE_W-1:0] code_acc [13];
  assign rank_above[0] = 1'b0;
  assign code_acc[0] = rank_win[0] ? rank_code[0] : {CODE_W{1'b0}};
  for (genvar g = 1; g < 13; g++) begin : g_rank
    assign rank_above[g] = rank_above[g-1] || rank_hit[g-1];
    // Win vector is one-hot, so an OR of masked codes picks one
    assign code_acc[g] = code_acc[g-1] | (rank_win[g] ? rank_code[g] : {CODE_W{1'b0}});
  end
  assign rank_win = rank_hit & ~rank_above;

  wire any_hit = |rank_hit;
  wire static_fail = hit_malformed || hit_early_absent;
  wire [CODE_W-1:0] outcome_code = any_hit ? code_acc[12] : RES_SUCCESS;

  // Sequencing: one outcome per query
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take_query && static_fail) begin
          state_nxt = ST_DONE;
        end else if (take_query) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (take_fetch) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Code moves only on a finished query and holds the last outcome
  wire code_load = (take_query && static_fail) || take_fetch;
  assign result_code_nxt = code_load ? outcome_code : result_code_r;
  wire busy_nxt = (state_nxt != ST_IDLE);
  wire fetch_req_nxt = (state_nxt == ST_WAIT);
  wire result_valid_nxt = (state_nxt == ST_DONE);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_code_r <= RESULT_RST;
    end else begin
      result_code_r <= result_code_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fetch_req_r <= 1'b0;
    end else begin
      fetch_req_r <= fetch_req_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= result_valid_nxt;
    end
  end

  assign busy = busy_r;
  assign fetch_req = fetch_req_r;
  assign result_valid = result_valid_r;
  assign result_code = result_code_r;
endmodule : translation_query_fault_check

// ### dv/translation_query_fault_check_monitor.sv
// Checker of outcome timing and ranking for the query checker
`timescale 1ns/10ps
module translation_query_fault_check_monitor (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic query_start,
  input wire logic query_type_valid,
  input wire logic fetch_done,
  input wire logic stream_index_range_error,
  input wire logic busy,
  input wire logic fetch_req,
  input wire logic result_valid,
  input wire logic [tq_pkg::CODE_W-1:0] result_code
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire take_w = query_start && !busy;
  wire got_w = fetch_req && fetch_done;
  a_bad_request: assert property (take_w && !query_type_valid |=> result_valid && result_code == 8'hFF)
    else $error("bad request code");
  a_range_first: assert property (got_w && stream_index_range_error |=> result_code == 8'h02)
    else $error("range not first");
  a_fetch_answer: assert property (got_w |=> result_valid && !fetch_req)
    else $error("late answer");
  a_fetch_hold: assert property (fetch_req && !fetch_done |=> fetch_req)
    else $error("fetch dropped");
  a_one_pulse: assert property (result_valid |=> !result_valid)
    else $error("long pulse");
  a_result_cause: assert property ($rose(result_valid) |-> $past(take_w) || $past(got_w))
    else $error("stray result");
  a_code_stable: assert property (!result_valid |-> $stable(result_code))
    else $error("code moved");
  a_busy_start: assert property (take_w |=> busy)
    else $error("not busy");
endmodule : translation_query_fault_check_monitor
bind translation_query_fault_check translation_query_fault_check_monitor i_monitor (.*);

// ### dv/translation_query_fault_check_tb.sv
// Bench for the query outcome checker
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("mismatch %0t code", $time); end end
module translation_query_fault_check_tb;
  logic clock = 0, rst_b = 0, query_start = 0, guest_scoped = 0, query_type_valid = 1, secure_query_flag = 0;
  logic secure_stage2_supported = 0, fetch_done = 0, busy, fetch_req, result_valid;
  logic [1:0] query_type = 2'h1;
  logic [5:0] ent = 6'h30;
  logic [8:0] err = 9'h000;
  logic [15:0] guest_query_selector = '0, stage2_guest_tag = 16'h1234;
  logic [7:0] desc_stage2_code = 8'h10, translation_code = 8'h13, result_code;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  translation_query_fault_check i_dut (.*, .stream_entry_valid(ent[5]), .entry_s1_en(ent[4]),
    .entry_s2_en(ent[3]), .entry_secure(ent[2]), .stream_regime(ent[1:0]), .stream_index_range_error(err[8]),
    .stream_entry_fetch_abort(err[7]), .vm_structure_fetch_abort(err[6]), .substream_range_error(err[5]),
    .substream_blocked(err[4]), .desc_stage2_fault(err[3]), .descriptor_fetch_abort(err[2]),
    .descriptor_invalid_error(err[1]), .translation_fault(err[0]));
  always #20 clock = ~clock;
  // Entry bits: valid, stage1, stage2, secure, regime
  task automatic go(input logic [5:0] en, input logic [15:0] sel, input logic [8:0] er, input logic [7:0] e);
    ent = en;
    guest_query_selector = sel;
    err = er;
    @(negedge clock) query_start = 1;
    @(negedge clock) query_start = 0;
    if (fetch_req === 1'b1) begin
      fetch_done = 1;
      @(negedge clock) fetch_done = 0;
    end
    `CHK(result_valid, 1'b1)
    `CHK(result_code, e)
    `CHK(busy, 1'b1)
    `CHK(fetch_req, 1'b0)
    @(negedge clock);
    `CHK(result_valid, 1'b0)
    `CHK(busy, 1'b0)
  endtask : go
  task automatic t_ranking;
    logic [7:0] exp_q [9] = '{8'h02, 8'h03, 8'h25, 8'h08, 8'h06, 8'h10, 8'h09, 8'h0A, 8'h13};
    for (int i = 0; i < 9; i++) go(6'h30, '0, 9'h1FF >> i, exp_q[i]);
    go(6'h10, '0, 9'h07F, 8'h04);
    query_type = 2'h2;
    go(6'h30, '0, 9'h03F, 8'hFE);
    query_type_valid = 0;
    go(6'h30, '0, 9'h1FF, 8'hFF);
    query_type_valid = 1;
    secure_query_flag = 1;
    go(6'h2D, '0, 9'h100, 8'hFE);
    secure_stage2_supported = 1;
    go(6'h2D, '0, 9'h000, 8'h00);
    query_type = 2'h3;
    go(6'h2D, '0, 9'h000, 8'hFE);
    query_type = 2'h1;
    secure_query_flag = 0;
  endtask : t_ranking
  task automatic t_guest;
    guest_scoped = 1;
    query_type_valid = 0;
    go(6'h30, 16'h1234, 9'h000, 8'hFF);
    query_type_valid = 1;
    go(6'h30, 16'h1234, 9'h010, 8'h06);
    go(6'h30, 16'h1235, 9'h000, 8'h04);
    go(6'h35, '0, 9'h000, 8'h00);
    go(6'h25, 16'h1234, 9'h000, 8'h04);
    go(6'h28, 16'h1234, 9'h000, 8'hFE);
  endtask : t_guest
  task automatic complete_run;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Whole run is about eighty cycles
  always @(posedge clock) if (++cyc == 2000) begin mismatches++; complete_run(); end
  initial begin
    repeat (2) @(negedge clock);
    rst_b = 1;
    t_ranking();
    t_guest();
    complete_run();
  end
endmodule : translation_query_fault_check_tb
